// ---- i2cbe_pkg.sv ----
package i2cbe_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS  = 4;
	localparam int HOLD_LONG_NS   = 300;
	localparam int HOLD_SHORT_NS  = 100;
	localparam int HALF_SCL_NS    = 1250;
	// least times, so round up to whole cycles
	localparam int HOLD_LONG_CYC  =
		(HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_SHORT_CYC =
		(HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HALF_SCL_CYC   =
		(HALF_SCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int CNT_W = 9;
	localparam logic [CNT_W-1:0] HOLD_LONG_CNT  = CNT_W'(HOLD_LONG_CYC);
	localparam logic [CNT_W-1:0] HOLD_SHORT_CNT = CNT_W'(HOLD_SHORT_CYC);
	localparam logic [CNT_W-1:0] HALF_SCL_CNT   = CNT_W'(HALF_SCL_CYC);
	localparam logic [CNT_W-1:0] CNT_ZERO       = 9'h000;

	// ==========================================================
	// byte format: eight data bits, then the acknowledge slot
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_ACK   = 4'h8;
	localparam logic [7:0] BYTE_RST  = 8'h00;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic       start;
		logic       stop;
		logic       write;
		logic       read;
		logic       nack;
		logic [7:0] data;
	} i2cbe_cmd_t;

	typedef struct packed {
		logic bus_busy;
		logic ack_result;
		logic collision;
		logic arb_lost;
		logic host_owner;
		logic client_engaged;
	} i2cbe_status_t;

	typedef struct packed {
		logic start_seen;
		logic stop_seen;
		logic byte_done;
		logic cmd_done;
		logic port_irq_set;
	} i2cbe_event_t;

endpackage

// ---- i2cbe_engine.sv ----
`timescale 1ns/1ps
// Behaviour
// [RULE_01] transfers are nine-bit units: eight data bits then one acknowledge bit
// [RULE_02] after the eighth falling clock, the sender releases data and samples acknowledge
// [RULE_03] data changes only while clock is low; sampled on rising clock
// [RULE_04] enabled in bus mode, both pins are open-drain: pull low or release
// [RULE_05] software sets both pin directions to input before using the bus mode
// [RULE_06] long-hold select keeps data valid 300 ns after falling clock
// [RULE_07] clock release clear: wait for clock low, then hold it low
// [RULE_08] host clock generation absorbs client stretching invisibly
// [RULE_09] host tracks start/stop and begins only when the bus is idle
// [RULE_10] transmitter compares sampled data with driven; mismatch loses arbitration
// [RULE_11] host losing arbitration also stops driving the clock
// [RULE_12] sampled low data while releasing high flags a bus collision
// [RULE_13] start is data falling with clock high; bus becomes active
// [RULE_14] data already low before pulling it for a start is a collision
// [RULE_15] stop is data rising with clock high, after one clock low period
// [RULE_16] start/stop interrupt enables act only in client modes lacking them
// [RULE_17] restart accepted like stop, resets client logic like a start
// [RULE_18] ten-bit read: after restart and read address, client holds clock
// [RULE_19] ninth pulse: transmitter releases data, accepting receiver pulls it low
// [RULE_20] sampled acknowledge of each transmitted byte goes to ack result
// [RULE_21] with both hold enables, client acknowledge comes from software value
// [RULE_22] client withholds acknowledge when buffer full or overflow is set
// [RULE_23] bytes are shifted most significant bit first
// [RULE_24] a complete received byte goes to the buffer and raises the irq
// [RULE_25] clock and data inputs pass two flops before edge detection
module i2cbe_engine
	import i2cbe_pkg::*;
(
	input  wire logic          sys_clk,
	input  wire logic          rstn,
	input  wire logic          port_enable,
	input  wire logic          i2c_mode,
	input  wire logic          host_mode,
	input  wire logic          client_irq_native,
	input  wire logic          start_irq_enable,
	input  wire logic          stop_irq_enable,
	input  wire logic          sda_hold_long,
	input  wire logic          clock_release,
	input  wire logic          address_hold_enable,
	input  wire logic          data_hold_enable,
	input  wire logic          ack_value_select,
	input  wire logic          buffer_full_flag,
	input  wire logic          receive_overflow_flag,
	input  wire logic          addr_match,
	input  wire logic          tx_load,
	input  wire logic [7:0]    tx_data,
	input  wire logic          status_clear,
	input  wire logic          cmd_valid,
	input  wire i2cbe_cmd_t    cmd,
	output logic               cmd_ready,
	input  wire logic          scl_in,
	output logic               scl_out,
	output logic               scl_oe,
	input  wire logic          sda_in,
	output logic               sda_out,
	output logic               sda_oe,
	output logic [7:0]         rx_tx_buffer,
	output i2cbe_status_t      status,
	output i2cbe_event_t       events
);

	typedef enum {H_IDLE, H_START, H_WAIT, H_LOW, H_HIGH,
		H_RSTRT, H_STOP_A, H_STOP_B, H_STOP_C} i2cbe_host_t;

	// ==========================================================
	// input synchronisers
	logic [2:0] scl_sy_r;
	logic [2:0] sda_sy_r;

	// stage 0 is read only by stage 1
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			scl_sy_r <= 3'h7;
			sda_sy_r <= 3'h7;
		end else begin
			scl_sy_r <= {scl_sy_r[1:0], scl_in}; // RULE_25
			sda_sy_r <= {sda_sy_r[1:0], sda_in}; // RULE_25
		end
	end

	logic en, scl, sda, scl_rise, scl_fall;
	logic start_det, stop_det;
	assign en        = port_enable & i2c_mode;
	assign scl       = scl_sy_r[1];
	assign sda       = sda_sy_r[1];
	assign scl_rise  = scl_sy_r[1] & ~scl_sy_r[2];
	assign scl_fall  = ~scl_sy_r[1] & scl_sy_r[2];
	// data edge with clock high on both samples
	assign start_det = en & ~sda & sda_sy_r[2] & scl & scl_sy_r[2]; // RULE_13

	// ==========================================================
	// bus monitor, bit engine and client
	logic            busy_r, busy_nxt, low_seen_r, low_seen_nxt;
	logic [3:0]      bit_r, bit_nxt;
	logic            rose_r, rose_nxt;
	logic [7:0]      shift_r, shift_nxt, buf_r, buf_nxt;
	logic            tx_r, tx_nxt, ack_low_r, ack_low_nxt;
	logic            first_r, first_nxt, eng_r, eng_nxt;
	logic            rdw_r, rdw_nxt, cl_scl_r, cl_scl_nxt;
	logic            dlow_r, dlow_nxt, pend_r, pend_nxt;
	logic            pval_r, pval_nxt;
	logic [CNT_W-1:0] hold_r, hold_nxt;
	i2cbe_status_t   st_r, st_nxt;
	i2cbe_event_t    ev_r, ev_nxt;
	logic            arb_evt, coll_evt, host_accept, host_done;
	logic            client;
	i2cbe_host_t     h_r, h_nxt;

	assign client   = en & ~host_mode;
	// a stop needs one clock low period since the last start or stop
	assign stop_det = en & sda & ~sda_sy_r[2] & scl & scl_sy_r[2]
		& low_seen_r; // RULE_15
	// released bit read back low while this end transmits
	assign arb_evt  = en & scl_rise & tx_r & (bit_r != BIT_ACK)
		& ~dlow_r & ~sda & (eng_r | host_mode); // RULE_10 RULE_12

	always_comb begin
		busy_nxt     = busy_r;
		low_seen_nxt = low_seen_r | ~scl;
		bit_nxt      = bit_r;
		rose_nxt     = rose_r;
		shift_nxt    = shift_r;
		buf_nxt      = buf_r;
		tx_nxt       = tx_r;
		ack_low_nxt  = ack_low_r;
		first_nxt    = first_r;
		eng_nxt      = eng_r;
		rdw_nxt      = rdw_r;
		dlow_nxt     = dlow_r;
		pend_nxt     = pend_r;
		pval_nxt     = pval_r;
		hold_nxt     = (hold_r == CNT_ZERO) ? CNT_ZERO : hold_r - 9'h001;
		st_nxt       = st_r;
		ev_nxt       = '0;
		// hold time runs from the detected falling clock
		if (pend_r && hold_r == CNT_ZERO) begin
			dlow_nxt = pval_r; // RULE_06 RULE_03
			pend_nxt = 1'b0;
		end
		if (scl_rise) begin
			rose_nxt = 1'b1;
			if (bit_r != BIT_ACK)
				shift_nxt = {shift_r[6:0], sda}; // RULE_23
			else if (tx_r) begin
				st_nxt.ack_result = sda; // RULE_20
				if (client && sda) begin
					eng_nxt = 1'b0; // host refused more data
					tx_nxt  = 1'b0;
				end
			end
		end
		if (scl_fall && rose_r) begin
			rose_nxt = 1'b0;
			pend_nxt = 1'b1;
			hold_nxt = sda_hold_long ? HOLD_LONG_CNT : HOLD_SHORT_CNT; // RULE_06
			pval_nxt = 1'b0;
			if (bit_r == BIT_ACK) begin
				// ninth pulse done; next byte starts
				bit_nxt = BIT_FIRST; // RULE_01
				ev_nxt.byte_done = tx_r;
				if (client && first_r && eng_r && shift_r[0]) begin
					tx_nxt  = 1'b1;
					rdw_nxt = 1'b1; // RULE_18
				end
				first_nxt = 1'b0;
			end else begin
				bit_nxt = bit_r + 4'h1;
				if (bit_r == 4'h7) begin
					if (!tx_r) begin
						buf_nxt = shift_r; // RULE_24
						ev_nxt.byte_done = 1'b1; // RULE_24
						if (client && first_r)
							eng_nxt = addr_match;
						if (client) begin
							if (address_hold_enable && data_hold_enable)
								pval_nxt = ~ack_value_select; // RULE_21
							else
								pval_nxt = ~(buffer_full_flag
									| receive_overflow_flag); // RULE_22
							pval_nxt = pval_nxt
								& (first_r ? addr_match : eng_r);
						end else
							pval_nxt = ack_low_r; // RULE_19
					end
					// transmitter lets go for the acknowledge
				end else if (tx_r)
					pval_nxt = ~shift_r[7]; // RULE_02 RULE_23
			end
		end
		// client read data handed over while the clock is held
		if (client && rdw_r && tx_load) begin
			shift_nxt = tx_data;
			rdw_nxt   = 1'b0;
			pend_nxt  = 1'b0;
			dlow_nxt  = ~tx_data[7]; // RULE_23
		end
		if (host_accept) begin
			tx_nxt      = cmd.write;
			shift_nxt   = cmd.data;
			ack_low_nxt = ~cmd.nack;
			pend_nxt    = 1'b0;
			dlow_nxt    = cmd.write & ~cmd.data[7];
		end
		if (arb_evt) begin
			dlow_nxt = 1'b0; // RULE_10
			pend_nxt = 1'b0;
			tx_nxt   = 1'b0;
			eng_nxt  = 1'b0;
			st_nxt.arb_lost = host_mode;
		end
		if (start_det || stop_det) begin
			// start and restart reset all client logic
			bit_nxt      = BIT_FIRST; // RULE_17
			rose_nxt     = 1'b0;
			first_nxt    = start_det;
			eng_nxt      = 1'b0;
			rdw_nxt      = 1'b0;
			low_seen_nxt = 1'b0;
			busy_nxt     = start_det; // RULE_09 RULE_13
			if (client)
				tx_nxt = 1'b0;
		end
		ev_nxt.start_seen = start_det;
		ev_nxt.stop_seen  = stop_det;
		ev_nxt.cmd_done   = host_done;
		// enables only matter where the mode lacks these interrupts
		ev_nxt.port_irq_set = ev_nxt.byte_done | (client & ((start_det
			& (client_irq_native | start_irq_enable)) | (stop_det
			& (client_irq_native | stop_irq_enable)))); // RULE_16
		if (status_clear) begin
			st_nxt.collision = 1'b0;
			st_nxt.arb_lost  = 1'b0;
		end
		// events win over a clear in the same cycle
		if (arb_evt || coll_evt)
			st_nxt.collision = 1'b1; // RULE_12 RULE_14
		if (arb_evt && host_mode)
			st_nxt.arb_lost = 1'b1; // RULE_11
		// clock stretch waits for the line to be low first
		cl_scl_nxt = client & (~clock_release | rdw_nxt)
			& (cl_scl_r | ~scl); // RULE_07 RULE_18
		st_nxt.bus_busy       = busy_nxt;
		st_nxt.host_owner     = (h_nxt != H_IDLE);
		st_nxt.client_engaged = eng_nxt;
		// clearing the enable is the module reset
		if (!en) begin
			busy_nxt = 1'b0;
			low_seen_nxt = 1'b0;
			bit_nxt = BIT_FIRST;
			rose_nxt = 1'b0;
			tx_nxt = 1'b0;
			first_nxt = 1'b0;
			eng_nxt = 1'b0;
			rdw_nxt = 1'b0;
			dlow_nxt = 1'b0;
			pend_nxt = 1'b0;
			cl_scl_nxt = 1'b0;
			st_nxt = '0;
			ev_nxt = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			busy_r <= 1'b0;
			low_seen_r <= 1'b0;
			bit_r <= BIT_FIRST;
			rose_r <= 1'b0;
			shift_r <= BYTE_RST;
			buf_r <= BYTE_RST;
			tx_r <= 1'b0;
			ack_low_r <= 1'b0;
			first_r <= 1'b0;
			eng_r <= 1'b0;
			rdw_r <= 1'b0;
			cl_scl_r <= 1'b0;
			dlow_r <= 1'b0;
			pend_r <= 1'b0;
			pval_r <= 1'b0;
			hold_r <= CNT_ZERO;
			st_r <= '0;
			ev_r <= '0;
		end else begin
			busy_r <= busy_nxt;
			low_seen_r <= low_seen_nxt;
			bit_r <= bit_nxt;
			rose_r <= rose_nxt;
			shift_r <= shift_nxt;
			buf_r <= buf_nxt;
			tx_r <= tx_nxt;
			ack_low_r <= ack_low_nxt;
			first_r <= first_nxt;
			eng_r <= eng_nxt;
			rdw_r <= rdw_nxt;
			cl_scl_r <= cl_scl_nxt;
			dlow_r <= dlow_nxt;
			pend_r <= pend_nxt;
			pval_r <= pval_nxt;
			hold_r <= hold_nxt;
			st_r <= st_nxt;
			ev_r <= ev_nxt;
		end
	end

	// ==========================================================
	// host sequencer
	logic [CNT_W-1:0] h_cnt_r, h_cnt_nxt;
	logic             h_scl_r, h_scl_nxt, h_sda_r, h_sda_nxt;
	logic             h_en, h_zero;

	assign h_en   = en & host_mode;
	assign h_zero = (h_cnt_r == CNT_ZERO);

	always_comb begin
		h_nxt       = h_r;
		h_cnt_nxt   = h_zero ? CNT_ZERO : h_cnt_r - 9'h001;
		h_scl_nxt   = h_scl_r;
		h_sda_nxt   = h_sda_r;
		host_accept = 1'b0;
		host_done   = 1'b0;
		coll_evt    = 1'b0;
		cmd_ready   = 1'b0;
		unique case (h_r)
			H_IDLE: begin
				cmd_ready = h_en & ~busy_r; // RULE_09
				if (cmd_ready && cmd_valid && cmd.start) begin
					if (!sda || !scl)
						coll_evt = 1'b1; // RULE_14
					else begin
						h_sda_nxt = 1'b1;
						h_cnt_nxt = HALF_SCL_CNT;
						h_nxt     = H_START;
					end
				end
			end
			H_START: if (h_zero) begin
				h_scl_nxt = 1'b1;
				h_cnt_nxt = HALF_SCL_CNT;
				h_nxt     = H_WAIT;
			end
			H_WAIT: begin
				// owning the bus with the clock low is stretching
				cmd_ready = h_zero;
				if (cmd_ready && cmd_valid) begin
					h_cnt_nxt = HALF_SCL_CNT;
					if (cmd.start) begin
						h_sda_nxt = 1'b0;
						h_nxt     = H_RSTRT; // RULE_17
					end else if (cmd.stop) begin
						h_sda_nxt = 1'b1;
						h_nxt     = H_STOP_A;
					end else if (cmd.write || cmd.read) begin
						h_sda_nxt   = 1'b0;
						host_accept = 1'b1;
						h_nxt       = H_LOW;
					end
				end
			end
			H_LOW: if (h_zero) begin
				h_scl_nxt = 1'b0;
				h_cnt_nxt = HALF_SCL_CNT;
				h_nxt     = H_HIGH;
			end
			H_HIGH: begin
				if (!scl)
					h_cnt_nxt = HALF_SCL_CNT; // RULE_08
				else if (h_zero) begin
					h_scl_nxt = 1'b1;
					h_cnt_nxt = HALF_SCL_CNT;
					if (bit_r == BIT_ACK) begin
						host_done = 1'b1;
						h_nxt     = H_WAIT;
					end else
						h_nxt = H_LOW;
				end
			end
			H_RSTRT: begin
				if (h_scl_r && h_zero) begin
					h_scl_nxt = 1'b0;
					h_cnt_nxt = HALF_SCL_CNT;
				end else if (!h_scl_r && !scl)
					h_cnt_nxt = HALF_SCL_CNT; // RULE_08
				else if (!h_scl_r && h_zero) begin
					if (!sda) begin
						coll_evt  = 1'b1; // RULE_14
						h_nxt     = H_IDLE;
					end else begin
						h_sda_nxt = 1'b1;
						h_cnt_nxt = HALF_SCL_CNT;
						h_nxt     = H_START;
					end
				end
			end
			H_STOP_A: if (h_zero) begin
				h_scl_nxt = 1'b0;
				h_cnt_nxt = HALF_SCL_CNT;
				h_nxt     = H_STOP_B;
			end
			H_STOP_B: begin
				if (!scl)
					h_cnt_nxt = HALF_SCL_CNT; // RULE_08
				else if (h_zero) begin
					h_sda_nxt = 1'b0;
					h_cnt_nxt = HALF_SCL_CNT;
					h_nxt     = H_STOP_C;
				end
			end
			H_STOP_C: if (h_zero) begin
				host_done = 1'b1;
				h_nxt     = H_IDLE;
			end
		endcase
		// losing arbitration gives up both lines
		if (!h_en || arb_evt) begin
			h_nxt     = H_IDLE; // RULE_11
			h_scl_nxt = 1'b0;
			h_sda_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			h_r     <= H_IDLE;
			h_cnt_r <= CNT_ZERO;
			h_scl_r <= 1'b0;
			h_sda_r <= 1'b0;
		end else begin
			h_r     <= h_nxt;
			h_cnt_r <= h_cnt_nxt;
			h_scl_r <= h_scl_nxt;
			h_sda_r <= h_sda_nxt;
		end
	end

	// ==========================================================
	// open-drain pins: only ever pull low or let go
	assign scl_out      = 1'b0;
	assign sda_out      = 1'b0;
	assign scl_oe       = en & (host_mode ? h_scl_r : cl_scl_r); // RULE_04
	assign sda_oe       = en & (dlow_r | h_sda_r); // RULE_04
	assign rx_tx_buffer = buf_r;
	assign status       = st_r;
	assign events       = ev_r;

endmodule

// ---- i2cbe_props.sv ----
`timescale 1ns/1ps
// ==========================================================
// bus engine checker, pins, ready, status and events only
module i2cbe_props
	import i2cbe_pkg::*;
(
	input wire logic          sys_clk,
	input wire logic          rstn,
	input wire logic          port_enable,
	input wire logic          i2c_mode,
	input wire logic          host_mode,
	input wire logic          sda_hold_long,
	input wire logic          address_hold_enable,
	input wire logic          data_hold_enable,
	input wire logic          buffer_full_flag,
	input wire logic          receive_overflow_flag,
	input wire logic          cmd_ready,
	input wire logic          scl_in,
	input wire logic          scl_out,
	input wire logic          scl_oe,
	input wire logic          sda_in,
	input wire logic          sda_out,
	input wire logic          sda_oe,
	input wire i2cbe_status_t status,
	input wire i2cbe_event_t  events
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic [7:0] low_cnt_r;
	logic [7:0] low_cnt_nxt;
	logic       low_seen_r;
	logic       low_seen_nxt;
	logic       sda_q_r;
	logic       en;
	assign en = port_enable & i2c_mode;
	// clock low time saturates, so a long clock low phase cannot wrap to zero
	always_comb begin
		low_cnt_nxt = scl_in ? 8'h00 : low_cnt_r + {7'h00, ~&low_cnt_r};
		low_seen_nxt = ~scl_in | (low_seen_r & ~(sda_in ^ sda_q_r));
	end
	// raw pin view, no synchroniser lag in the reference
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			low_cnt_r <= 8'h00;
			low_seen_r <= 1'b0;
			sda_q_r <= 1'b1;
		end else begin
			low_cnt_r <= low_cnt_nxt;
			low_seen_r <= low_seen_nxt;
			sda_q_r <= sda_in;
		end
	end
	sequence s_fall;
		en && scl_in && $fell(sda_in);
	endsequence
	sequence s_rise;
		en && scl_in && $rose(sda_in);
	endsequence
	property p_od;
		!scl_out && !sda_out;
	endproperty
	a_od: assert property (p_od) else $error("pin driven high");
	property p_off;
		!en |-> !scl_oe && !sda_oe;
	endproperty
	a_off: assert property (p_off) else $error("pull while off");
	// while the host owns the bus, ready only paces its own commands
	property p_rdy;
		(cmd_ready && !status.host_owner) |-> !status.bus_busy;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready on busy");
	property p_hold;
		(!host_mode && !scl_in && !scl_oe && $changed(sda_oe)) |->
			low_cnt_r >= (sda_hold_long ? HOLD_LONG_CYC : HOLD_SHORT_CYC);
	endproperty
	a_hold: assert property (p_hold) else $error("hold too short");
	property p_stretch;
		($rose(scl_oe) && !host_mode) |-> !$past(scl_in) && !$past(scl_in, 2);
	endproperty
	a_stretch: assert property (p_stretch) else $error("early hold");
	property p_start;
		s_fall |-> ##[1:5] events.start_seen;
	endproperty
	a_start: assert property (p_start) else $error("start missed");
	property p_stop;
		(s_rise ##0 low_seen_r) |-> ##[1:5] events.stop_seen;
	endproperty
	a_stop: assert property (p_stop) else $error("stop missed");
	property p_nostop;
		(s_rise ##0 !low_seen_r) |-> ##1 (!events.stop_seen) [*6];
	endproperty
	a_nostop: assert property (p_nostop) else $error("bad stop");
	property p_byte;
		(!host_mode && events.byte_done) |-> events.port_irq_set;
	endproperty
	a_byte: assert property (p_byte) else $error("no byte irq");
	property p_nak;
		(!host_mode && events.byte_done && !(address_hold_enable &&
			data_hold_enable) && (buffer_full_flag || receive_overflow_flag))
			|-> ##90 !sda_oe;
	endproperty
	a_nak: assert property (p_nak) else $error("acked when full");
endmodule

// ---- i2cbe_far.sv ----
`timescale 1ns/1ps
// ==========================================================
// far side: behavioural host, plus a client that acks
module i2cbe_far #(
	parameter int HI = 8,
	parameter int LO = 100
) (
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic ack_en,
	output logic      scl_pull,
	output logic      sda_pull
);
	logic h_sda = 1'b0;
	logic c_sda = 1'b0;
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	int   n = 0;
	// open drain: released lines float up through the pull-up
	assign sda_pull = h_sda | c_sda;
	initial scl_pull = 1'b0;
	task automatic wt(input int k);
		repeat (k) @(posedge clk);
	endtask
	// long low phase leaves room for the slowest data hold
	task automatic bitx(input logic b, output logic s);
		h_sda <= ~b;
		wt(LO);
		scl_pull <= 1'b0;
		do wt(1); while (!scl);
		wt(HI / 2);
		s = sda;
		wt(HI / 2);
		scl_pull <= 1'b1;
		wt(1);
	endtask
	task automatic put(input logic [7:0] d, output logic a);
		logic s;
		for (int i = 7; i >= 0; i--) bitx(d[i], s);
		bitx(1'b1, a);
	endtask
	task automatic start;
		h_sda <= 1'b1;
		wt(HI);
		scl_pull <= 1'b1;
		wt(2);
	endtask
	// pulls the clock low first, so it is legal from any bus state
	task automatic stop;
		scl_pull <= 1'b1;
		wt(LO);
		h_sda <= 1'b1;
		wt(LO);
		scl_pull <= 1'b0;
		wt(HI);
		h_sda <= 1'b0;
		wt(HI);
	endtask
	// data falls then rises with the clock high all along: start only
	task automatic glitch;
		h_sda <= 1'b1;
		wt(HI);
		h_sda <= 1'b0;
		wt(HI);
	endtask
	// client: count clock falls, pull data through the ninth bit
	always @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (scl && scl_q && sda_q && !sda)
			n <= 0;
		else if (scl_q && !scl) begin
			n <= (n == 9) ? 1 : n + 1;
			c_sda <= ack_en && (n == 8);
		end
	end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
// ==========================================================
// bench: far side drives the wires, engine seen at its ports
module tb_top;
	import i2cbe_pkg::*;
	logic          sys_clk = 1'b0;
	logic          rstn = 1'b0;
	logic          port_enable = 1'b1;
	logic          i2c_mode = 1'b1;
	logic          host_mode = 1'b0;
	logic          client_irq_native = 1'b0;
	logic          start_irq_enable = 1'b1;
	logic          stop_irq_enable = 1'b1;
	logic          sda_hold_long = 1'b0;
	logic          clock_release = 1'b1;
	logic          address_hold_enable = 1'b0;
	logic          data_hold_enable = 1'b0;
	logic          ack_value_select = 1'b0;
	logic          buffer_full_flag = 1'b0;
	logic          receive_overflow_flag = 1'b0;
	logic          cmd_valid = 1'b0;
	logic          ack_en = 1'b0;
	logic          a;
	i2cbe_cmd_t    cmd = '0;
	i2cbe_status_t status;
	i2cbe_event_t  events;
	logic [7:0]    rx_tx_buffer;
	logic          cmd_ready, scl_oe, sda_oe, p_scl, p_sda;
	int            num_errors = 0;
	int            n_checks = 0;
	int            st_n = 0;
	int            bd_n = 0;
	int            ir_n = 0;
	int            sp_n = 0;
	int            cd_n = 0;
	// {hold_long, full, overflow, addr_hold, data_hold, ack_value, nack}
	logic [6:0]    tbl [5] = '{7'h00, 7'h61, 7'h11, 7'h6C, 7'h0F};
	// wired-and bus with pull-ups
	wire scl = !(scl_oe || p_scl);
	wire sda = !(sda_oe || p_sda);
	always #2 sys_clk = ~sys_clk;
	i2cbe_engine uut (.scl_in(scl), .sda_in(sda), .addr_match(1'b1),
		.tx_load(1'b0), .tx_data(8'h00), .status_clear(1'b0),
		.scl_out(), .sda_out(), .*);
	i2cbe_far far (.clk(sys_clk), .scl(scl), .sda(sda), .ack_en(ack_en),
		.scl_pull(p_scl), .sda_pull(p_sda));
	// running totals of event pulses
	always @(posedge sys_clk) begin
		st_n <= st_n + int'(events.start_seen);
		sp_n <= sp_n + int'(events.stop_seen);
		bd_n <= bd_n + int'(events.byte_done);
		ir_n <= ir_n + int'(events.port_irq_set);
		cd_n <= cd_n + int'(events.cmd_done);
	end
	task automatic wt(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	// compares away from the edge that updates the outputs
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		@(negedge sys_clk);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// host command: wait for ready, one accepted edge, wait byte end on a write
	task automatic hcmd(input i2cbe_cmd_t c);
		int k;
		int c0;
		@(negedge sys_clk);
		for (k = 0; k < 9000 && cmd_ready !== 1'b1; k++) @(negedge sys_clk);
		@(posedge sys_clk);
		cmd <= c;
		cmd_valid <= 1'b1;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		c0 = cd_n;
		for (k = 0; k < 9000 && c.write && cd_n == c0; k++) @(posedge sys_clk);
	endtask
	initial begin
		wt(80000);
		num_errors++;
		end_sim;
	end
	initial begin
		wt(6);
		rstn <= 1'b1;
		wt(3);
		chk(rx_tx_buffer, 8'h00);
		chk({sda_oe, scl_oe, status}, 8'h00);
		far.start;
		far.put(8'hA6, a);
		chk(a, 1'b0);
		chk(rx_tx_buffer, 8'hA6);
		chk(8'(st_n), 8'h01);
		chk(8'(ir_n), 8'h02);
		$display("test 1 done");
		for (int i = 0; i < 5; i++) begin
			wt(90);
			{sda_hold_long, buffer_full_flag, receive_overflow_flag,
				address_hold_enable, data_hold_enable,
				ack_value_select} <= tbl[i][6:1];
			far.put(8'h35 + 8'(i), a);
			chk(a, tbl[i][0]);
			chk(rx_tx_buffer, 8'h35 + 8'(i));
		end
		chk(8'(bd_n), 8'h06);
		$display("test 2 done");
		wt(90);
		{address_hold_enable, data_hold_enable, ack_value_select,
			clock_release} <= 4'h0;
		fork
			far.put(8'hC3, a);
			begin
				wt(500);
				chk({scl_oe, scl}, 8'h02);
				wt(1);
				clock_release <= 1'b1;
			end
		join
		chk(a, 1'b0);
		$display("test 3 done");
		// native start/stop irq mode: enables must not matter
		{client_irq_native, start_irq_enable, stop_irq_enable} <= 3'h4;
		far.stop;
		far.glitch;
		wt(10);
		chk(8'(sp_n), 8'h01);
		chk(8'(st_n), 8'h02);
		far.stop;
		wt(10);
		chk(8'(sp_n), 8'h02);
		chk(8'(ir_n), 8'h0B);
		chk(status.bus_busy, 1'b0);
		$display("test 4 done");
		{port_enable, i2c_mode, start_irq_enable, stop_irq_enable} <= 4'h0;
		wt(4);
		{port_enable, i2c_mode, host_mode, ack_en} <= 4'hF;
		far.start;
		wt(10);
		chk(cmd_ready, 1'b0);
		far.stop;
		wt(10);
		chk(cmd_ready, 1'b1);
		hcmd('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00});
		hcmd('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'hA5});
		chk(status.ack_result, 1'b0);
		ack_en <= 1'b0;
		hcmd('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h5A});
		chk(status.ack_result, 1'b1);
		hcmd('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00});
		wt(2000);
		chk(8'(sp_n), 8'h04);
		$display("test 5 done");
		end_sim;
	end
endmodule
bind i2cbe_engine i2cbe_props u_props (.*);
